//--- inc/pwrid_consts.svh
`ifndef PWRID_CONSTS_SVH
`define PWRID_CONSTS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PWRID_ADDR_VENDOR 16'h0400
`define PWRID_ADDR_PART 16'h0404
`define PWRID_ADDR_PWRBW 16'h22F0
`define PWRID_ADDR_WAVE 16'h22F4

// ----------------------------------------
// power and bandwidth layout
// ----------------------------------------
`define PWRID_PWRBW_RESET 32'h0008_8800
`define PWRID_HP_BIT 0
`define PWRID_BW_LSB 2
`define PWRID_BW_MSB 3
`define PWRID_RW_MASK 32'h0000_000D

// ----------------------------------------
// identity fields
// ----------------------------------------
`define PWRID_ID_LSB 4
`define PWRID_ID_MSB 15
`define PWRID_REV_MSB 3

// ----------------------------------------
// automatic bandwidth thresholds and the high power crossover, in hertz
// ----------------------------------------
`define PWRID_F_50K 24'd50000
`define PWRID_F_100K 24'd100000
`define PWRID_F_80K 24'd80000

`endif

//--- inc/pwrid_pkg.sv
package pwrid_pkg;
	// filter cutoff settings driven to the analog paths
	typedef enum logic [1:0] {
		PWRID_CUT_AUTO,
		PWRID_CUT_50K,
		PWRID_CUT_100K,
		PWRID_CUT_250K
	} pwrid_cut_type;
endpackage : pwrid_pkg

//--- logic/pwrid_cutoff_sel.sv
`timescale 1ns/1ns
`include "pwrid_consts.svh"

module pwrid_cutoff_sel (
	input wire logic [1:0] bw_field,
	input wire logic [23:0] wave_freq,
	output pwrid_pkg::pwrid_cut_type cutoff
);
	always_comb begin
		unique case (bw_field)
			2'h0: begin
				// auto range; below the lowest band the 50k filter is kept
				if (wave_freq > `PWRID_F_100K) begin
					cutoff = pwrid_pkg::PWRID_CUT_250K;
				end else if (wave_freq > `PWRID_F_50K) begin
					cutoff = pwrid_pkg::PWRID_CUT_100K;
				end else begin
					cutoff = pwrid_pkg::PWRID_CUT_50K;
				end
			end
			2'h1: cutoff = pwrid_pkg::PWRID_CUT_50K;
			2'h2: cutoff = pwrid_pkg::PWRID_CUT_100K;
			2'h3: cutoff = pwrid_pkg::PWRID_CUT_250K;
		endcase
	end
endmodule : pwrid_cutoff_sel

//--- logic/pwrid_id_rom.sv
`timescale 1ns/1ns
`include "pwrid_consts.svh"

module pwrid_id_rom #(
	// arbitrary neutral values
	parameter logic [15:0] VENDOR_CODE = 16'h1234,
	parameter logic [11:0] DEVICE_CODE = 12'hABC,
	parameter logic [3:0] REVISION = 4'h1
) (
	output logic [31:0] vendor_word,
	output logic [31:0] part_word
);
	// constants only: nothing software does can alter these
	assign vendor_word = {16'h0000, VENDOR_CODE};
	// device code is per revision, so the pair is set together at build
	assign part_word = {16'h0000, DEVICE_CODE, REVISION};
endmodule : pwrid_id_rom

//--- logic/pwrid_regs.sv
`timescale 1ns/1ns
`include "pwrid_consts.svh"

// Functional notes
// - bits 3:2 of power config set DAC and ADC filter bandwidth together
// - field 00 picks cutoff automatically from waveform frequency
// - auto: 50 to 100 kHz waveform gives 100 kHz cutoff
// - auto: 100 to 200 kHz waveform gives 250 kHz cutoff
// - field 01 fixes cutoff at 50 kHz
// - field 10 fixes cutoff at 100 kHz
// - field 11 fixes cutoff at 250 kHz
// - bit 0 selects high power mode, resets to low power
// - identity registers are read only and readable any time
// - vendor register returns fixed 16-bit code
// - part register: device code bits 15:4, revision bits 3:0
// - device code differs between silicon revisions

module pwrid_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic high_power_select,
	output pwrid_pkg::pwrid_cut_type cutoff
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [31:0] cfg_r;
	logic [31:0] cfg_nxt;
	logic [23:0] wave_r;
	logic [23:0] wave_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic err_r;
	logic err_nxt;
	logic [31:0] vendor_word;
	logic [31:0] part_word;
	logic setup;
	logic access;
	logic hit;
	logic [31:0] bmask;
	logic [1:0] bw_field;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign setup = psel && !penable;
	assign access = psel && penable;
	// unmapped addresses answer with an error and take no write
	assign hit = (paddr == `PWRID_ADDR_VENDOR) ||
		(paddr == `PWRID_ADDR_PART) ||
		(paddr == `PWRID_ADDR_PWRBW) ||
		(paddr == `PWRID_ADDR_WAVE);

	// one mask byte per strobe lane; a cleared lane keeps its old bits
	for (genvar g = 0; g < 4; g++) begin : g_lane
		assign bmask[g*8 +: 8] = {8{pstrb[g]}};
	end

	pwrid_id_rom u_id (
		.vendor_word(vendor_word),
		.part_word(part_word)
	);

	// one field steers both filters, so they can never disagree
	assign bw_field = cfg_r[`PWRID_BW_MSB:`PWRID_BW_LSB];

	pwrid_cutoff_sel u_cut (
		.bw_field(bw_field),
		.wave_freq(wave_r),
		.cutoff(cutoff)
	);

	assign high_power_select = cfg_r[`PWRID_HP_BIT];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		cfg_nxt = cfg_r;
		wave_nxt = wave_r;
		rdata_nxt = rdata_r;
		err_nxt = 1'b0;
		// no wait state: answer is prepared in setup, given in access
		if (setup) begin
			err_nxt = !hit;
			rdata_nxt = 32'h0000_0000;
			if (!pwrite) begin
				unique case (paddr)
					`PWRID_ADDR_VENDOR: rdata_nxt = vendor_word;
					`PWRID_ADDR_PART: rdata_nxt = part_word;
					`PWRID_ADDR_PWRBW: rdata_nxt = cfg_r;
					`PWRID_ADDR_WAVE: rdata_nxt = {8'h00, wave_r};
					default: rdata_nxt = 32'h0000_0000;
				endcase
			end
		end
		if (access && pwrite && pready) begin
			if (paddr == `PWRID_ADDR_PWRBW) begin
				// only bits 3:2 and 0 take writes; the rest hold reset
				cfg_nxt = (cfg_r & ~(`PWRID_RW_MASK & bmask)) |
					(pwdata & `PWRID_RW_MASK & bmask);
			end else if (paddr == `PWRID_ADDR_WAVE) begin
				wave_nxt = (wave_r & ~bmask[23:0]) |
					(pwdata[23:0] & bmask[23:0]);
			end
		end
	end

	// pready is tied high: every access ends without wait states

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= `PWRID_PWRBW_RESET;
			wave_r <= 24'h00_0000;
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else begin
			cfg_r <= cfg_nxt;
			wave_r <= wave_nxt;
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
		end
	end

	// always ready: the read word was staged during setup
	assign pready = 1'b1;
	assign prdata = rdata_r;
	// error is only shown while the access phase stands
	assign pslverr = access && err_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// bus phases as seen at the rising edge
	sequence cfg_write_s;
		psel && penable && pwrite && (paddr == `PWRID_ADDR_PWRBW);
	endsequence

	sequence rd_setup_s(logic [15:0] a);
		psel && !penable && !pwrite && (paddr == a);
	endsequence

	sequence id_write_s;
		psel && penable && pwrite &&
		(paddr == `PWRID_ADDR_VENDOR || paddr == `PWRID_ADDR_PART);
	endsequence

	sequence wave_write_s;
		psel && penable && pwrite && (paddr == `PWRID_ADDR_WAVE);
	endsequence

	sequence no_write_s;
		!(psel && penable && pwrite);
	endsequence

	cfg_reset_a: assert property (@(posedge pclk)
		$rose(presetn) |-> cfg_r == `PWRID_PWRBW_RESET)
		else $error("config not at reset value");

	reserved_hold_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		(cfg_r & ~`PWRID_RW_MASK) ==
		(`PWRID_PWRBW_RESET & ~`PWRID_RW_MASK))
		else $error("reserved config bits changed");

	hp_write_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		cfg_write_s ##0 pstrb[0] |=>
		high_power_select == $past(pwdata[0]))
		else $error("high power bit not written");

	fix50_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		cfg_r[3:2] == 2'h1 |-> cutoff == pwrid_pkg::PWRID_CUT_50K)
		else $error("cutoff not 50k");

	fix100_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		cfg_r[3:2] == 2'h2 |-> cutoff == pwrid_pkg::PWRID_CUT_100K)
		else $error("cutoff not 100k");

	fix250_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		cfg_r[3:2] == 2'h3 |-> cutoff == pwrid_pkg::PWRID_CUT_250K)
		else $error("cutoff not 250k");

	auto_mid_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		cfg_r[3:2] == 2'h0 && wave_r > `PWRID_F_50K &&
		wave_r <= `PWRID_F_100K |-> cutoff == pwrid_pkg::PWRID_CUT_100K)
		else $error("auto cutoff not 100k");

	auto_high_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		cfg_r[3:2] == 2'h0 && wave_r > `PWRID_F_100K |->
		cutoff == pwrid_pkg::PWRID_CUT_250K)
		else $error("auto cutoff not 250k");

	vendor_read_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_setup_s(`PWRID_ADDR_VENDOR) |=> prdata == vendor_word)
		else $error("vendor read wrong");

	part_read_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_setup_s(`PWRID_ADDR_PART) |=> prdata == part_word)
		else $error("part read wrong");

	// ----------------------------------------
	// configuration state checks
	// ----------------------------------------
	auto_low_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		bw_field == 2'h0 && wave_r <= `PWRID_F_50K |->
		cutoff == pwrid_pkg::PWRID_CUT_50K)
		else $error("auto cutoff not 50k");

	bw_write_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		cfg_write_s ##0 pstrb[0] |=>
		bw_field == $past(pwdata[`PWRID_BW_MSB:`PWRID_BW_LSB]))
		else $error("bandwidth field not written");

	lane_drop_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		cfg_write_s ##0 !pstrb[0] |=> $stable(cfg_r))
		else $error("masked config write landed");

	id_write_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		id_write_s |=> $stable(cfg_r) && $stable(wave_r))
		else $error("identity write changed state");

	// nothing but an access edge may move the stored state
	state_hold_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		no_write_s |=> $stable(cfg_r) && $stable(wave_r))
		else $error("state changed without write");

	wave_write_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		wave_write_s ##0 (pstrb == 4'hF) |=>
		wave_r == $past(pwdata[23:0]))
		else $error("frequency not written");

	wave_lane_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		wave_write_s ##0 !pstrb[0] |=>
		wave_r[7:0] == $past(wave_r[7:0]))
		else $error("masked frequency lane written");

	// ----------------------------------------
	// bus answer checks
	// ----------------------------------------
	unmapped_err_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		access && !hit |-> pslverr)
		else $error("unmapped access without error");

	mapped_ok_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		access && hit |-> !pslverr)
		else $error("error on a mapped access");

	err_idle_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		!access |-> !pslverr)
		else $error("error outside access phase");

	unmapped_read_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		psel && !penable && !pwrite && !hit |=>
		prdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	cfg_read_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_setup_s(`PWRID_ADDR_PWRBW) |=> prdata == $past(cfg_r))
		else $error("config read wrong");

	id_upper_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_setup_s(`PWRID_ADDR_PART) |=>
		prdata[31:16] == 16'h0000)
		else $error("part read upper half not zero");

	// read data stands until the next setup, so slow masters still see it
	rd_hold_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		!setup |=> $stable(prdata))
		else $error("read data moved outside setup");
endmodule : pwrid_regs

//--- tb/tb_top.sv
`timescale 1ns/1ns
`include "pwrid_consts.svh"

module tb_top;
	// arbitrary codes, equal to the identity rom defaults
	localparam logic [31:0] VEND_W = 32'h0000_1234;
	localparam logic [31:0] PART_W = 32'h0000_ABC1;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic high_power_select;
	pwrid_pkg::pwrid_cut_type cutoff;
	int mismatches = 0;
	int checks_done = 0;
	logic [31:0] rv;
	logic ev;
	logic hp_want;
	logic [23:0] fq [4] = '{24'h00C350, 24'h00EA60, 24'h0186A0, 24'h0249F0};
	logic [1:0] ct [4] = '{2'h1, 2'h2, 2'h2, 2'h3};

	always #20 pclk = ~pclk;

	pwrid_regs u_pwrid_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.high_power_select(high_power_select), .cutoff(cutoff));

	task automatic end_sim;
		if (mismatches == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// ----------------------------------------
	// apb master
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// wait states allowed: pready high ends this wait, else the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic rdc(input logic [15:0] a, input logic [31:0] e,
		input logic er);
		xfer(1'b0, a, 32'h0000_0000, 4'h0);
		chk(rv, e);
		chk({31'h0, ev}, {31'h0, er});
	endtask : rdc

	// levels checked mid-cycle, away from the updating edge
	task automatic lvl(input logic hp, input logic [1:0] c);
		@(negedge pclk);
		chk({31'h0, high_power_select}, {31'h0, hp});
		chk({30'h0, cutoff}, {30'h0, c});
		chk({31'h0, pready}, 32'h0000_0001);
	endtask : lvl

	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		end_sim();
	end

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		lvl(1'b0, 2'h1);
		rdc(`PWRID_ADDR_PWRBW, 32'h0008_8800, 1'b0);
		rdc(`PWRID_ADDR_VENDOR, VEND_W, 1'b0);
		rdc(`PWRID_ADDR_PART, PART_W, 1'b0);
		xfer(1'b1, `PWRID_ADDR_VENDOR, 32'hFFFF_FFFF, 4'hF);
		xfer(1'b1, `PWRID_ADDR_PART, 32'h0000_0000, 4'hF);
		rdc(`PWRID_ADDR_VENDOR, VEND_W, 1'b0);
		rdc(`PWRID_ADDR_PART, PART_W, 1'b0);
		xfer(1'b1, `PWRID_ADDR_PWRBW, 32'hFFFF_FFFF, 4'hF);
		rdc(`PWRID_ADDR_PWRBW, 32'h0008_880D, 1'b0);
		lvl(1'b1, 2'h3);
		// lane 0 off: the whole write must be dropped
		xfer(1'b1, `PWRID_ADDR_PWRBW, 32'h0000_0000, 4'hE);
		rdc(`PWRID_ADDR_PWRBW, 32'h0008_880D, 1'b0);
		rdc(16'h0100, 32'h0000_0000, 1'b1);
		xfer(1'b1, `PWRID_ADDR_WAVE, 32'h0002_49F0, 4'hF);
		// lane 0 off: only the upper frequency bytes are cleared
		xfer(1'b1, `PWRID_ADDR_WAVE, 32'h0000_0000, 4'hE);
		rdc(`PWRID_ADDR_WAVE, 32'h0000_00F0, 1'b0);
		for (int i = 1; i < 4; i++) begin
			xfer(1'b1, `PWRID_ADDR_PWRBW, {28'h0, i[1:0], 2'h0}, 4'hF);
			lvl(1'b0, i[1:0]);
		end
		xfer(1'b1, `PWRID_ADDR_PWRBW, 32'h0000_0001, 4'hF);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, `PWRID_ADDR_WAVE, {8'h00, fq[i]}, 4'hF);
			// high power only for tones above the crossover
			hp_want = fq[i] > `PWRID_F_80K;
			xfer(1'b1, `PWRID_ADDR_PWRBW, {31'h0, hp_want}, 4'hF);
			lvl(hp_want, ct[i]);
		end
		// reset in mid-run must drop high power and the frequency
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		lvl(1'b0, 2'h1);
		rdc(`PWRID_ADDR_PWRBW, `PWRID_PWRBW_RESET, 1'b0);
		end_sim();
	end
endmodule : tb_top
